/* File: include/dscdma_pkg.sv */
// Purpose: Shared constants for the dual channel sample capture DMA block.
// Assumes: 200 MHz system clock, 16-bit bank words, 4k words per bank.
// Notes:   Times are kept in their own unit; cycle counts derive from them.
package dscdma_pkg;

    localparam int          SYS_CLK_KHZ       = 200000;
    localparam int          DATA_W            = 16;
    localparam int          SAMPLE_W          = 12;
    localparam int          BANK_WORDS        = 4096;
    localparam int          ADDR_W            = 12;
    // Least sample spacing at the top conversion rate of 300 kHz
    localparam int          MAX_CONV_KHZ      = 300;
    localparam int          SAMPLE_CYC        = SYS_CLK_KHZ / MAX_CONV_KHZ;
    // System bus word address: bit 0 picks the bank, bits above the word
    localparam int          SYS_ADDR_W        = 13;
    localparam logic [12:0] SYS_BANK_BIT      = 13'h0001;
    // Controller register offsets on the system bus (register space)
    localparam logic [1:0]  REG_BASE_OFS      = 2'h0;
    localparam logic [1:0]  REG_COUNT_OFS     = 2'h1;
    localparam logic [1:0]  REG_CTRL_OFS      = 2'h2;
    localparam logic [1:0]  REG_STAT_OFS      = 2'h3;
    // Control register field positions
    localparam int          CTRL_TRIG_SEL_BIT = 0;
    // Reset values
    localparam logic [11:0] BASE_RST          = 12'h000;
    localparam logic [11:0] COUNT_RST         = 12'h000;
    localparam logic        TRIG_SEL_RST      = 1'b0;

    typedef enum logic [2:0]
    {
        DSC_IDLE    = 3'b000,
        DSC_HOLD    = 3'b001,
        DSC_ADDR    = 3'b010,
        DSC_WRITE   = 3'b011,
        DSC_RELEASE = 3'b100
    } dscdma_state_t;

endpackage

/* File: logic/dscdma_sync.sv */
// Purpose: Two-stage synchroniser for a bundle of asynchronous levels.
// Assumes: Inputs are levels from outside the clock domain.
// Notes:   Only the second stage is visible to the outside.
`timescale 1ns/1ps
`default_nettype none
module dscdma_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             arst_n,
    // Levels
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_reg;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_reg <= '0;
            dout     <= '0;
        end
        else
        begin
            meta_reg <= din;
            dout     <= meta_reg;
        end
    end
endmodule
`default_nettype wire

/* File: logic/dscdma_top.sv */
// Purpose: Capture paired voltage/current samples into two local banks by DMA.
// Assumes: Converter and trigger pins are asynchronous; system bus is synchronous.
// Notes:   Bank data ports are modelled as two internal memories with a muxed port.
// Contract
// - Accept paired samples up to 300 kHz with no processor work per sample.
// - Two banks of 4k 16-bit words: voltage bank and current bank.
// - Bus isolate high connects banks to converters, low to the system bus.
// - Bank data direction follows the active read or write strobe.
// - Samples are 12 bits; storage and transfer paths are 16 bits.
// - Only channel 0; processor programs base and count before each capture.
// - Software selects final-count or interval-end trigger; only that one counts.
// - Selected trigger sets capture enable; end of process clears it.
// - Request flip-flop loads capture enable on both end-of-conversion signals.
// - Demand mode: a request raises the hold request.
// - Hold request passes two flip-flops and returns locally as hold acknowledge.
// - After acknowledge, assert bus isolate and drive local address and strobes.
// - Low address byte direct; upper byte on data lines latched by strobe.
// - Latched upper byte drives upper address lines only while isolated.
// - DMA writes enable both banks: 4k by 32 to DMA, 8k by 16 to bus.
// - Channel acknowledge clears the request flip-flop for the next pair.
// - After the programmed count, end of process clears enable and interrupts.
// - Interval-end trigger is a pulse from the summation interval logic.
`timescale 1ns/1ps
`default_nettype none
module dscdma_top
    import dscdma_pkg::*;
#(
    parameter int WORDS = BANK_WORDS
) (
    // Clock and reset
    input  wire logic                  SYS_CLK,
    input  wire logic                  ARST_N,
    // Converter side, asynchronous
    input  wire logic [SAMPLE_W-1:0]   VOLT_SAMPLE,
    input  wire logic [SAMPLE_W-1:0]   CURR_SAMPLE,
    input  wire logic                  VOLT_EOC,
    input  wire logic                  CURR_EOC,
    // Sequence triggers, asynchronous
    input  wire logic                  FINAL_COUNT_TRIGGER,
    input  wire logic                  INTERVAL_END_TRIGGER,
    // System bus, synchronous
    input  wire logic                  SYS_MEM_SEL,
    input  wire logic                  SYS_REG_SEL,
    input  wire logic                  SYS_RD,
    input  wire logic                  SYS_WR,
    input  wire logic [SYS_ADDR_W-1:0] SYS_ADDR,
    input  wire logic [DATA_W-1:0]     SYS_WDATA,
    output logic      [DATA_W-1:0]     SYS_RDATA,
    output logic                       SYS_RDATA_OE,
    output logic                       SYS_REFUSED,
    // Status and completion
    output logic                       BUS_ISOLATE,
    output logic                       CAPTURE_ENABLE,
    output logic                       CHANNEL_REQUEST,
    output logic                       HOLD_REQUEST,
    output logic                       HOLD_ACKNOWLEDGE,
    output logic                       CHANNEL_ACKNOWLEDGE,
    output logic                       UPPER_ADDRESS_STROBE,
    output logic                       WRITE_STROBE,
    output logic [ADDR_W-1:0]          CAPTURE_ADDR,
    output logic                       END_OF_PROCESS,
    output logic                       DONE_IRQ
);
    typedef struct packed {
        dscdma_state_t     state;
        logic              trig_sel;
        logic [ADDR_W-1:0] base;
        logic [ADDR_W-1:0] count;
        logic [ADDR_W-1:0] cur_addr;
        logic [ADDR_W-1:0] remain;
        logic              capture_enable;
        logic              channel_request;
        logic              hold_request;
        logic [1:0]        hold_delay;
        logic              bus_isolate;
        logic              channel_ack;
        logic              write_strobe;
        logic              upper_strobe;
        logic [7:0]        upper_latch;
        logic              eop;
        logic              done_irq;
        logic              pair_prev;
        logic              fc_prev;
        logic              tc_prev;
        logic [DATA_W-1:0] rdata;
        logic              rdata_oe;
        logic              refused;
    } dscdma_regs_t;

    dscdma_regs_t s_reg;
    dscdma_regs_t s_next;

    logic [DATA_W-1:0] volt_bank [WORDS];
    logic [DATA_W-1:0] curr_bank [WORDS];
    logic [2*SAMPLE_W+3:0] pin_sync;
    logic [DATA_W-1:0] volt_word;
    logic [DATA_W-1:0] curr_word;
    logic [ADDR_W-1:0] full_addr;
    logic [ADDR_W-1:0] sys_word;
    logic              sys_bank_curr;
    logic              pair_ready;
    logic              trig_edge;
    logic              bank_wr_dma;
    logic              bank_wr_sys;
    logic              sys_access;

    // All pin-side inputs pass two flip-flops before use
    dscdma_sync #(
        .WIDTH (2*SAMPLE_W+4)
    ) u_sync (
        .clk    (SYS_CLK),
        .arst_n (ARST_N),
        .din    ({VOLT_SAMPLE, CURR_SAMPLE, VOLT_EOC, CURR_EOC,
                  FINAL_COUNT_TRIGGER, INTERVAL_END_TRIGGER}),
        .dout   (pin_sync)
    );

    // Samples widened to the 16-bit storage path
    assign volt_word     = {{(DATA_W-SAMPLE_W){1'b0}}, pin_sync[2*SAMPLE_W+3:SAMPLE_W+4]};
    assign curr_word     = {{(DATA_W-SAMPLE_W){1'b0}}, pin_sync[SAMPLE_W+3:4]};
    assign pair_ready    = pin_sync[3] & pin_sync[2];
    assign sys_word      = SYS_ADDR[SYS_ADDR_W-1:1];
    assign sys_bank_curr = SYS_ADDR[0];
    assign sys_access    = (SYS_MEM_SEL | SYS_REG_SEL) & (SYS_RD | SYS_WR);
    // Address is zero unless isolated; then low byte direct, upper bits from the latch
    assign full_addr     = s_reg.bus_isolate ?
                           {s_reg.upper_latch[ADDR_W-9:0], s_reg.cur_addr[7:0]} :
                           {ADDR_W{1'b0}};
    // Only the selected trigger source is honoured, on its rising edge
    assign trig_edge     = s_reg.trig_sel ? (pin_sync[0] & ~s_reg.tc_prev)
                                          : (pin_sync[1] & ~s_reg.fc_prev);
    assign bank_wr_dma   = s_reg.write_strobe & s_reg.bus_isolate;
    assign bank_wr_sys   = SYS_MEM_SEL & SYS_WR & ~s_reg.bus_isolate;

    // Next-state logic of the whole channel
    always_comb
    begin
        s_next              = s_reg;
        s_next.fc_prev      = pin_sync[1];
        s_next.tc_prev      = pin_sync[0];
        s_next.pair_prev    = pair_ready;
        s_next.channel_ack  = 1'b0;
        s_next.write_strobe = 1'b0;
        s_next.upper_strobe = 1'b0;
        s_next.eop          = 1'b0;
        s_next.rdata_oe     = 1'b0;
        s_next.refused      = 1'b0;
        s_next.done_irq     = 1'b0;

        // Capture enable: set by trigger, cleared by end of process (set wins)
        if (s_reg.eop)
            s_next.capture_enable = 1'b0;
        if (trig_edge)
            s_next.capture_enable = 1'b1;

        // Request loads enable on the rising edge of the paired EOC
        if (s_reg.channel_ack)
            s_next.channel_request = 1'b0;
        if (pair_ready && !s_reg.pair_prev)
            s_next.channel_request = s_reg.capture_enable;

        // Hold loopback through two flip-flops, never leaving the board
        s_next.hold_delay = {s_reg.hold_delay[0], s_reg.hold_request};

        // Channel sequencer, demand transfer mode
        unique case (s_reg.state)
            DSC_IDLE:
            begin
                if (s_reg.channel_request && s_reg.remain != '0)
                begin
                    s_next.hold_request = 1'b1;
                    s_next.state        = DSC_HOLD;
                end
            end
            DSC_HOLD:
            begin
                if (s_reg.hold_delay[1])
                begin
                    s_next.bus_isolate  = 1'b1;
                    s_next.upper_latch  = {{(16-ADDR_W){1'b0}}, s_reg.cur_addr[ADDR_W-1:8]};
                    s_next.upper_strobe = 1'b1;
                    s_next.state        = DSC_ADDR;
                end
            end
            DSC_ADDR:
            begin
                s_next.write_strobe = 1'b1;
                s_next.channel_ack  = 1'b1;
                s_next.state        = DSC_WRITE;
            end
            DSC_WRITE:
            begin
                s_next.cur_addr = s_reg.cur_addr + 1'b1;
                s_next.remain   = s_reg.remain - 1'b1;
                if (s_reg.remain == 12'h001)
                begin
                    s_next.eop      = 1'b1;
                    s_next.done_irq = 1'b1;
                end
                s_next.state = DSC_RELEASE;
            end
            DSC_RELEASE:
            begin
                // Demand mode holds the bus only while a request stands
                s_next.hold_request = 1'b0;
                s_next.bus_isolate  = 1'b0;
                s_next.state        = DSC_IDLE;
            end
            default:
            begin
                s_next.state = DSC_IDLE;
            end
        endcase

        // System bus access: refused whole while isolated
        if (sys_access && s_reg.bus_isolate)
            s_next.refused = 1'b1;
        else if (SYS_REG_SEL && SYS_WR)
        begin
            // Writing base reloads the address counter; writing count rearms the transfer counter
            unique case (SYS_ADDR[1:0])
                REG_BASE_OFS:
                begin
                    s_next.base     = SYS_WDATA[ADDR_W-1:0];
                    s_next.cur_addr = SYS_WDATA[ADDR_W-1:0];
                end
                REG_COUNT_OFS:
                begin
                    s_next.count  = SYS_WDATA[ADDR_W-1:0];
                    s_next.remain = SYS_WDATA[ADDR_W-1:0];
                end
                REG_CTRL_OFS:
                    s_next.trig_sel = SYS_WDATA[CTRL_TRIG_SEL_BIT];
                REG_STAT_OFS:
                    s_next.done_irq = s_reg.done_irq;
            endcase
        end
        else if (SYS_REG_SEL && SYS_RD)
        begin
            s_next.rdata_oe = 1'b1;
            unique case (SYS_ADDR[1:0])
                REG_BASE_OFS:  s_next.rdata = {{(DATA_W-ADDR_W){1'b0}}, s_reg.base};
                REG_COUNT_OFS: s_next.rdata = {{(DATA_W-ADDR_W){1'b0}}, s_reg.remain};
                REG_CTRL_OFS:  s_next.rdata = {15'h0000, s_reg.trig_sel};
                REG_STAT_OFS:  s_next.rdata = {12'h000, s_reg.capture_enable,
                                               s_reg.channel_request, s_reg.hold_request,
                                               s_reg.bus_isolate};
            endcase
        end
        else if (SYS_MEM_SEL && SYS_RD)
        begin
            // Bank read drives the bus; bit 0 picks voltage or current
            s_next.rdata_oe = 1'b1;
            s_next.rdata    = sys_bank_curr ? curr_bank[sys_word] : volt_bank[sys_word];
        end
    end

    // State register; reset leaves the banks on the system bus
    always_ff @(posedge SYS_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            s_reg                <= '0;
            s_reg.state          <= DSC_IDLE;
            s_reg.trig_sel       <= TRIG_SEL_RST;
            s_reg.base           <= BASE_RST;
            s_reg.count          <= COUNT_RST;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // Bank memories: both banks written together on a DMA cycle
    always_ff @(posedge SYS_CLK)
    begin
        if (bank_wr_dma)
        begin
            volt_bank[full_addr] <= volt_word;
            curr_bank[full_addr] <= curr_word;
        end
        else if (bank_wr_sys)
        begin
            if (sys_bank_curr)
                curr_bank[sys_word] <= SYS_WDATA;
            else
                volt_bank[sys_word] <= SYS_WDATA;
        end
    end

    // Output drive, all from flip-flops
    assign SYS_RDATA            = s_reg.rdata_oe ? s_reg.rdata : {DATA_W{1'b0}};
    assign SYS_RDATA_OE         = s_reg.rdata_oe;
    assign SYS_REFUSED          = s_reg.refused;
    assign BUS_ISOLATE          = s_reg.bus_isolate;
    assign CAPTURE_ENABLE       = s_reg.capture_enable;
    assign CHANNEL_REQUEST      = s_reg.channel_request;
    assign HOLD_REQUEST         = s_reg.hold_request;
    assign HOLD_ACKNOWLEDGE     = s_reg.hold_delay[1];
    assign CHANNEL_ACKNOWLEDGE  = s_reg.channel_ack;
    assign UPPER_ADDRESS_STROBE = s_reg.upper_strobe;
    assign WRITE_STROBE         = s_reg.write_strobe;
    assign CAPTURE_ADDR         = full_addr;
    assign END_OF_PROCESS       = s_reg.eop;
    assign DONE_IRQ             = s_reg.done_irq;
endmodule
`default_nettype wire

/* File: tb/dscdma_assertions.sv */
// Purpose: Port-level timing checks for the sample capture DMA block.
// Assumes: One clock domain; reset is asynchronous and active low.
// Notes:   Watches only what the design drives, apart from bus request causes.
`timescale 1ns/1ps
`default_nettype none
module dscdma_assertions
    import dscdma_pkg::*;
(
    // Clock and reset
    input wire logic              SYS_CLK,
    input wire logic              ARST_N,
    // System bus
    input wire logic              SYS_MEM_SEL,
    input wire logic              SYS_REG_SEL,
    input wire logic              SYS_RD,
    input wire logic              SYS_WR,
    input wire logic [DATA_W-1:0] SYS_RDATA,
    input wire logic              SYS_RDATA_OE,
    input wire logic              SYS_REFUSED,
    // Capture handshake and status
    input wire logic              BUS_ISOLATE,
    input wire logic              CAPTURE_ENABLE,
    input wire logic              CHANNEL_REQUEST,
    input wire logic              HOLD_REQUEST,
    input wire logic              HOLD_ACKNOWLEDGE,
    input wire logic              CHANNEL_ACKNOWLEDGE,
    input wire logic              UPPER_ADDRESS_STROBE,
    input wire logic              WRITE_STROBE,
    input wire logic [ADDR_W-1:0] CAPTURE_ADDR,
    input wire logic              END_OF_PROCESS,
    input wire logic              DONE_IRQ
);
    // Everything is sampled on the system clock and ignored during reset
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!ARST_N);
    // Local hold loop: two stages, no outside party involved
    property p_hold_loop; HOLD_ACKNOWLEDGE == $past(HOLD_REQUEST, 2); endproperty
    a_hold_loop: assert property (p_hold_loop) else $error("hold loop delay wrong");
    property p_req_hold; $rose(CHANNEL_REQUEST) |=> HOLD_REQUEST; endproperty
    a_req_hold: assert property (p_req_hold) else $error("request without hold");
    property p_req_cause; $rose(CHANNEL_REQUEST) |-> $past(CAPTURE_ENABLE); endproperty
    a_req_cause: assert property (p_req_cause) else $error("request while disabled");
    property p_iso_ack; $rose(BUS_ISOLATE) |-> HOLD_ACKNOWLEDGE && $past(HOLD_ACKNOWLEDGE); endproperty
    a_iso_ack: assert property (p_iso_ack) else $error("isolate before acknowledge");
    // Address and strobe sequence of one transfer
    property p_iso_addr; !BUS_ISOLATE |-> CAPTURE_ADDR == 12'h000; endproperty
    a_iso_addr: assert property (p_iso_addr) else $error("address leaks while attached");
    property p_strobe_seq;
        UPPER_ADDRESS_STROBE |-> BUS_ISOLATE ##1 WRITE_STROBE && CHANNEL_ACKNOWLEDGE && BUS_ISOLATE;
    endproperty
    a_strobe_seq: assert property (p_strobe_seq) else $error("strobe order wrong");
    property p_ack_clear; CHANNEL_ACKNOWLEDGE |=> !CHANNEL_REQUEST; endproperty
    a_ack_clear: assert property (p_ack_clear) else $error("request not cleared");
    property p_eop; END_OF_PROCESS |-> DONE_IRQ ##[1:2] !CAPTURE_ENABLE; endproperty
    a_eop: assert property (p_eop) else $error("end of process effects missing");
    // System bus answers; refusal must leave the data lines quiet
    property p_refuse;
        BUS_ISOLATE && (SYS_MEM_SEL || SYS_REG_SEL) && (SYS_RD || SYS_WR)
            |=> SYS_REFUSED && !SYS_RDATA_OE;
    endproperty
    a_refuse: assert property (p_refuse) else $error("isolated access not refused");
    property p_quiet; !SYS_RDATA_OE |-> SYS_RDATA == 16'h0000; endproperty
    a_quiet: assert property (p_quiet) else $error("read data driven without enable");
    property p_read_answer;
        !BUS_ISOLATE && (SYS_MEM_SEL || SYS_REG_SEL) && SYS_RD && !SYS_WR |=> SYS_RDATA_OE;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");
endmodule
bind dscdma_top dscdma_assertions dscdma_assertions_i (.SYS_CLK, .ARST_N, .SYS_MEM_SEL,
    .SYS_REG_SEL, .SYS_RD, .SYS_WR, .SYS_RDATA, .SYS_RDATA_OE, .SYS_REFUSED, .BUS_ISOLATE,
    .CAPTURE_ENABLE, .CHANNEL_REQUEST, .HOLD_REQUEST, .HOLD_ACKNOWLEDGE, .CHANNEL_ACKNOWLEDGE,
    .UPPER_ADDRESS_STROBE, .WRITE_STROBE, .CAPTURE_ADDR, .END_OF_PROCESS, .DONE_IRQ);
`default_nettype wire

/* File: tb/dscdma_adc_model.sv */
// Purpose: Far-side model: two converters and the sequence trigger source.
// Assumes: Commanded by the bench through its tasks, on the system clock.
// Notes:   Sample lines turn to inverted data once a result has lapsed.
`timescale 1ns/1ps
`default_nettype none
module dscdma_adc_model
    import dscdma_pkg::*;
(
    // Clock
    input  wire logic                SYS_CLK,
    // Converter results
    output logic      [SAMPLE_W-1:0] volt_sample,
    output logic      [SAMPLE_W-1:0] curr_sample,
    output logic                     volt_eoc,
    output logic                     curr_eoc,
    // Sequence triggers
    output logic                     final_count_trigger,
    output logic                     interval_end_trigger
);
    // Quiet lines at time zero
    initial
    begin
        {volt_sample, curr_sample} = 24'h000000;
        {volt_eoc, curr_eoc, final_count_trigger, interval_end_trigger} = 4'h0;
    end
    // One paired conversion; voltage ends first so only the pair may count
    task automatic convert(input logic [SAMPLE_W-1:0] v, input logic [SAMPLE_W-1:0] c);
        @(posedge SYS_CLK);
        {volt_sample, curr_sample} <= {v, c};
        repeat (4) @(posedge SYS_CLK);
        volt_eoc <= 1'b1;
        repeat (3) @(posedge SYS_CLK);
        curr_eoc <= 1'b1;
        // Result held past synchroniser and transfer, then it lapses
        repeat (16) @(posedge SYS_CLK);
        {volt_eoc, curr_eoc} <= 2'h0;
        {volt_sample, curr_sample} <= {~v, ~c};
        // Next pair no sooner than the top conversion rate allows
        repeat (SAMPLE_CYC) @(posedge SYS_CLK);
    endtask
    // Trigger pulse: 0 final count, 1 interval end
    task automatic fire(input logic which);
        @(posedge SYS_CLK);
        {final_count_trigger, interval_end_trigger} <= {!which, which};
        repeat (4) @(posedge SYS_CLK);
        {final_count_trigger, interval_end_trigger} <= 2'h0;
    endtask
endmodule
`default_nettype wire

/* File: tb/dscdma_top_bench.sv */
// Purpose: Self-checking bench for the dual channel sample capture DMA.
// Assumes: Bus strobes last one cycle; read answers land one cycle later.
// Notes:   Capture addresses are logged at each write strobe for later checks.
`timescale 1ns/1ps
`default_nettype none
module dscdma_top_bench
    import dscdma_pkg::*;
;
    // Bench drive and observed lines
    logic                  sys_clk, arst_n, mem_sel, reg_sel, rd, wr, rdata_oe, refused;
    logic [SYS_ADDR_W-1:0] addr;
    logic [DATA_W-1:0]     wdata, rdata, q;
    logic [SAMPLE_W-1:0]   volt_sample, curr_sample;
    logic                  volt_eoc, curr_eoc, fc_trig, ie_trig, oe, rf;
    logic                  isolate, cap_en, chan_req, hold_req, hold_ack, chan_ack;
    logic                  up_strobe, wr_strobe, eop, done_irq;
    logic [ADDR_W-1:0]     cap_addr;
    logic [ADDR_W-1:0]     cap_q[$];
    int                    err_count, samples_checked, eop_count, n;
    dscdma_top dscdma_top_i (.SYS_CLK(sys_clk), .ARST_N(arst_n), .VOLT_SAMPLE(volt_sample),
        .CURR_SAMPLE(curr_sample), .VOLT_EOC(volt_eoc), .CURR_EOC(curr_eoc),
        .FINAL_COUNT_TRIGGER(fc_trig), .INTERVAL_END_TRIGGER(ie_trig), .SYS_MEM_SEL(mem_sel),
        .SYS_REG_SEL(reg_sel), .SYS_RD(rd), .SYS_WR(wr), .SYS_ADDR(addr), .SYS_WDATA(wdata),
        .SYS_RDATA(rdata), .SYS_RDATA_OE(rdata_oe), .SYS_REFUSED(refused),
        .BUS_ISOLATE(isolate), .CAPTURE_ENABLE(cap_en), .CHANNEL_REQUEST(chan_req),
        .HOLD_REQUEST(hold_req), .HOLD_ACKNOWLEDGE(hold_ack), .CHANNEL_ACKNOWLEDGE(chan_ack),
        .UPPER_ADDRESS_STROBE(up_strobe), .WRITE_STROBE(wr_strobe), .CAPTURE_ADDR(cap_addr),
        .END_OF_PROCESS(eop), .DONE_IRQ(done_irq));
    dscdma_adc_model dscdma_adc_model_i (.SYS_CLK(sys_clk), .volt_sample(volt_sample),
        .curr_sample(curr_sample), .volt_eoc(volt_eoc), .curr_eoc(curr_eoc),
        .final_count_trigger(fc_trig), .interval_end_trigger(ie_trig));
    // 200 MHz clock
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // Log end-of-process pulses and the address of every paired write
    always @(posedge sys_clk)
    begin
        if (eop === 1'b1) eop_count++;
        if (wr_strobe === 1'b1) cap_q.push_back(cap_addr);
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) err_count++;
        if (got !== exp) $display("wrong value %s expected %h seen %h", what, exp, got);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // One bus cycle: strobe for one edge, answer sampled after the next
    task automatic access(input logic m, input logic r, input logic w,
                          input logic [12:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        {mem_sel, reg_sel, rd, wr, addr, wdata} <= {m, !m, r, w, a, d};
        @(posedge sys_clk);
        {mem_sel, reg_sel, rd, wr} <= 4'h0;
        #1;
        {q, oe, rf} = {rdata, rdata_oe, refused};
    endtask
    task automatic rd_chk(input string what, input logic m, input logic [12:0] a,
                          input logic [15:0] exp);
        access(m, 1'b1, 1'b0, a, 16'h0000);
        chk(what, exp, q);
        chk("read enable", 16'h0001, {15'h0000, oe});
    endtask
    task automatic trig_chk(input logic which, input logic exp);
        dscdma_adc_model_i.fire(which);
        repeat (8) @(posedge sys_clk);
        #1;
        chk("capture enable", {15'h0000, exp}, {15'h0000, cap_en});
    endtask
    initial
    begin
        {arst_n, mem_sel, reg_sel, rd, wr, addr, wdata} = 34'h0;
        {err_count, samples_checked, eop_count} = {32'd0, 32'd0, 32'd0};
        repeat (3) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        #1;
        chk("idle flags", 16'h0000, {10'h000, isolate, cap_en, chan_req, hold_req, eop, done_irq});
        rd_chk("base", 1'b0, {11'h000, REG_BASE_OFS}, {4'h0, BASE_RST});
        rd_chk("count", 1'b0, {11'h000, REG_COUNT_OFS}, {4'h0, COUNT_RST});
        rd_chk("ctrl", 1'b0, {11'h000, REG_CTRL_OFS}, {15'h0000, TRIG_SEL_RST});
        rd_chk("status", 1'b0, {11'h000, REG_STAT_OFS}, 16'h0000);
        $display("test reset finished");
        // Top word of each bank through the system bus while attached
        access(1'b1, 1'b0, 1'b1, {12'hFFF, 1'b0}, 16'hBEEF);
        access(1'b1, 1'b0, 1'b1, {12'hFFF, 1'b1}, 16'h1234);
        rd_chk("volt top word", 1'b1, {12'hFFF, 1'b0}, 16'hBEEF);
        rd_chk("curr top word", 1'b1, {12'hFFF, 1'b1}, 16'h1234);
        $display("test bus memory finished");
        // Two samples on the final-count trigger, a bus read refused mid-transfer
        access(1'b0, 1'b0, 1'b1, {11'h000, REG_BASE_OFS}, 16'h0A3E);
        access(1'b0, 1'b0, 1'b1, {11'h000, REG_COUNT_OFS}, 16'h0002);
        access(1'b0, 1'b0, 1'b1, {11'h000, REG_CTRL_OFS}, 16'h0000);
        trig_chk(1'b1, 1'b0);
        trig_chk(1'b0, 1'b1);
        fork
            dscdma_adc_model_i.convert(12'h5A3, 12'hA5C);
            begin
                for (n = 0; n < 200 && hold_ack !== 1'b1; n++) @(posedge sys_clk);
                chk("hold acknowledge", 16'h0001, {15'h0000, hold_ack});
                if (hold_ack !== 1'b1)
                    tally_and_finish();
                else
                begin
                    access(1'b1, 1'b1, 1'b0, {12'hA3E, 1'b0}, 16'h0000);
                    chk("refused flag", 16'h0001, {15'h0000, rf});
                    chk("refused data", 16'h0000, q);
                end
            end
        join
        dscdma_adc_model_i.convert(12'h001, 12'hFFF);
        dscdma_adc_model_i.convert(12'h777, 12'h888);
        #1;
        chk("end of process pulses", 16'h0001, eop_count[15:0]);
        chk("capture enable", 16'h0000, {15'h0000, cap_en});
        chk("transfers", 16'h0002, 16'(cap_q.size()));
        chk("first address", 16'h0A3E, {4'h0, cap_q[0]});
        chk("second address", 16'h0A3F, {4'h0, cap_q[1]});
        rd_chk("volt 0", 1'b1, {12'hA3E, 1'b0}, 16'h05A3);
        rd_chk("curr 0", 1'b1, {12'hA3E, 1'b1}, 16'h0A5C);
        rd_chk("volt 1", 1'b1, {12'hA3F, 1'b0}, 16'h0001);
        rd_chk("curr 1", 1'b1, {12'hA3F, 1'b1}, 16'h0FFF);
        $display("test final count capture finished");
        // Reprogrammed single sample on the interval-end trigger
        access(1'b0, 1'b0, 1'b1, {11'h000, REG_BASE_OFS}, 16'h0010);
        access(1'b0, 1'b0, 1'b1, {11'h000, REG_COUNT_OFS}, 16'h0001);
        access(1'b0, 1'b0, 1'b1, {11'h000, REG_CTRL_OFS}, 16'h0001);
        rd_chk("ctrl", 1'b0, {11'h000, REG_CTRL_OFS}, 16'h0001);
        trig_chk(1'b0, 1'b0);
        trig_chk(1'b1, 1'b1);
        dscdma_adc_model_i.convert(12'hFFF, 12'h000);
        #1;
        chk("end of process pulses", 16'h0002, eop_count[15:0]);
        chk("third address", 16'h0010, {4'h0, cap_q[2]});
        rd_chk("volt 2", 1'b1, {12'h010, 1'b0}, 16'h0FFF);
        $display("test interval end capture finished");
        tally_and_finish();
    end
endmodule
`default_nettype wire
